// ---- rtl/jtb_pkg.sv ----
// Constants and types shared by the test access port design
`default_nettype none
package jtb_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int IR_LEN = 5;
    localparam int ID_LEN = 32;
    localparam int NUM_IO = 4;
    localparam int BSR_LEN = 3 * NUM_IO;
    localparam int NUM_TEST_PINS = 4;
    localparam int TEST_IN_PINS = 3;
    localparam int BUF_WIDTH = 2;
    localparam int BUF_DEPTH = 2;

    // ------------------------------------------------------------
    // Boundary register layout: input, output and enable cells
    // ------------------------------------------------------------
    localparam int BSR_IN_LSB = 0;
    localparam int BSR_OUT_LSB = NUM_IO;
    localparam int BSR_OE_LSB = 2 * NUM_IO;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [IR_LEN-1:0] IR_EXTEST = 5'h00;
    localparam logic [IR_LEN-1:0] IR_IDCODE = 5'h01;
    localparam logic [IR_LEN-1:0] IR_SAMPLE = 5'h02;
    localparam logic [IR_LEN-1:0] IR_INTEST = 5'h03;
    localparam logic [IR_LEN-1:0] IR_HIGHZ = 5'h05;
    localparam logic [IR_LEN-1:0] IR_BYPASS = 5'h1f;
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 5'h01;

    // Arbitrary identification value, names no maker or part
    localparam logic [ID_LEN-1:0] IDCODE_VALUE = 32'h1234_5671;

    // Level of a test input pin while it is held by its pull-up
    localparam logic [TEST_IN_PINS-1:0] PULLED_HIGH = 3'h7;
    localparam logic [NUM_TEST_PINS-1:0] PULLUP_ALL = 4'hf;

    // ------------------------------------------------------------
    // Controller states and data register selection
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        TAP_RESET      = 16'h0001,
        TAP_IDLE       = 16'h0002,
        TAP_SEL_DR     = 16'h0004,
        TAP_CAPTURE_DR = 16'h0008,
        TAP_SHIFT_DR   = 16'h0010,
        TAP_EXIT1_DR   = 16'h0020,
        TAP_PAUSE_DR   = 16'h0040,
        TAP_EXIT2_DR   = 16'h0080,
        TAP_UPDATE_DR  = 16'h0100,
        TAP_SEL_IR     = 16'h0200,
        TAP_CAPTURE_IR = 16'h0400,
        TAP_SHIFT_IR   = 16'h0800,
        TAP_EXIT1_IR   = 16'h1000,
        TAP_PAUSE_IR   = 16'h2000,
        TAP_EXIT2_IR   = 16'h4000,
        TAP_UPDATE_IR  = 16'h8000
    } jtb_tap_state_type;

    typedef enum logic [2:0] {
        SEL_BYPASS = 3'h1,
        SEL_IDCODE = 3'h2,
        SEL_BSR    = 3'h4
    } jtb_sel_type;
endpackage
`default_nettype wire

// ---- rtl/jtb_buf2.sv ----
// Small valid/ready buffer held in flip-flops
`default_nettype none
module jtb_buf2 #(
    parameter int WIDTH = jtb_pkg::BUF_WIDTH,
    parameter int DEPTH = jtb_pkg::BUF_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != FULL_COUNT);
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    // Storage needs no reset; empty entries are never presented
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/jtb_tap_port.sv ----
// Boundary-scan test access port with test pin reclaim
`default_nettype none
// Overview of operation
// - Port has clock, mode, data-in, data-out pins only; no test reset.
// - Power-up reset puts controller and instruction register in reset.
// - Reclaim pin high returns the four test pins to test duty.
// - Reclaim pin low gives user-assigned test pins back to user I/O.
// - Erased device uses the test pins as test port without reclaim.
// - User-assigned test pins ignore test activity unless reclaimed.
// - Core logic near the test pins keeps working during test.
// - Test port pins keep weak pull-ups enabled.
// - Code 00010 samples pins, preloads boundary outputs undisturbed.
// - Code 00000 drives pins from the boundary register outputs.
// - Code 11111 puts one-bit bypass between data-in and data-out.
// - Instruction scan with data-in held high loads bypass.
// - Code 00001 shifts out the identification word.
// - Code 00101 floats all system outputs and selects bypass.
// - Code 00011 applies and captures patterns at the core logic.
// - Data-in sampled on rising test clock edge.
// - Data-out changes on falling test clock edge.
// - Data-out driven only while shifting, otherwise floating.
module jtb_tap_port (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic tck_pin_in,
    input wire logic tms_pin_in,
    input wire logic tdi_pin_in,
    output logic tdo_pin_out,
    output logic tdo_pin_oe_n,
    input wire logic port_enable_in,
    input wire logic cfg_erased,
    input wire logic cfg_test_pins_io,
    output logic [jtb_pkg::NUM_TEST_PINS-1:0] test_pin_pullup_en,
    output logic [jtb_pkg::TEST_IN_PINS-1:0] user_test_pin_in,
    input wire logic user_tdo_out,
    input wire logic user_tdo_oe_n,
    input wire logic [jtb_pkg::NUM_IO-1:0] pad_in,
    output logic [jtb_pkg::NUM_IO-1:0] pad_out,
    output logic [jtb_pkg::NUM_IO-1:0] pad_oe_n,
    input wire logic [jtb_pkg::NUM_IO-1:0] core_out,
    input wire logic [jtb_pkg::NUM_IO-1:0] core_oe_n,
    output logic [jtb_pkg::NUM_IO-1:0] core_in
);
    localparam int N = jtb_pkg::NUM_IO;

    // ------------------------------------------------------------
    // Pin synchronisers and test clock edges
    // ------------------------------------------------------------
    // Bit order of the test input group: tck, tms, tdi
    logic [2:0] tpin_s1_r;
    logic [2:0] tpin_s2_r;
    logic tck_d_r;
    logic pe_s1_r;
    logic pe_s2_r;
    logic [N-1:0] pad_s1_r;
    logic [N-1:0] pad_s2_r;
    logic port_active;
    logic tck_rise;
    logic tck_fall;
    logic tms_s;
    logic tdi_s;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tpin_s1_r <= jtb_pkg::PULLED_HIGH;
            tpin_s2_r <= jtb_pkg::PULLED_HIGH;
            tck_d_r <= 1'b1;
            pe_s1_r <= 1'b0;
            pe_s2_r <= 1'b0;
            pad_s1_r <= '0;
            pad_s2_r <= '0;
        end else begin
            tpin_s1_r <= {tck_pin_in, tms_pin_in, tdi_pin_in};
            tpin_s2_r <= tpin_s1_r;
            tck_d_r <= tpin_s2_r[2];
            pe_s1_r <= port_enable_in;
            pe_s2_r <= pe_s1_r;
            pad_s1_r <= pad_in;
            pad_s2_r <= pad_s1_r;
        end
    end

    // Reclaim is read as a level; it comes out of reset low
    assign port_active = cfg_erased |
                         ~cfg_test_pins_io | pe_s2_r;
    // Edges count only while the pins belong to the test port
    assign tck_rise = port_active & tpin_s2_r[2] & ~tck_d_r;
    assign tck_fall = port_active & ~tpin_s2_r[2] & tck_d_r;
    assign tms_s = tpin_s2_r[1];
    assign tdi_s = tpin_s2_r[0];

    // ------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------
    jtb_pkg::jtb_tap_state_type state_r;
    jtb_pkg::jtb_tap_state_type state_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            jtb_pkg::TAP_RESET: begin
                state_nxt = tms_s ? jtb_pkg::TAP_RESET : jtb_pkg::TAP_IDLE;
            end
            jtb_pkg::TAP_IDLE: begin
                state_nxt = tms_s ? jtb_pkg::TAP_SEL_DR : jtb_pkg::TAP_IDLE;
            end
            jtb_pkg::TAP_SEL_DR: begin
                state_nxt = tms_s ? jtb_pkg::TAP_SEL_IR
                                  : jtb_pkg::TAP_CAPTURE_DR;
            end
            jtb_pkg::TAP_CAPTURE_DR, jtb_pkg::TAP_SHIFT_DR: begin
                state_nxt = tms_s ? jtb_pkg::TAP_EXIT1_DR
                                  : jtb_pkg::TAP_SHIFT_DR;
            end
            jtb_pkg::TAP_EXIT1_DR: begin
                state_nxt = tms_s ? jtb_pkg::TAP_UPDATE_DR
                                  : jtb_pkg::TAP_PAUSE_DR;
            end
            jtb_pkg::TAP_PAUSE_DR: begin
                state_nxt = tms_s ? jtb_pkg::TAP_EXIT2_DR
                                  : jtb_pkg::TAP_PAUSE_DR;
            end
            jtb_pkg::TAP_EXIT2_DR: begin
                state_nxt = tms_s ? jtb_pkg::TAP_UPDATE_DR
                                  : jtb_pkg::TAP_SHIFT_DR;
            end
            jtb_pkg::TAP_UPDATE_DR, jtb_pkg::TAP_UPDATE_IR: begin
                state_nxt = tms_s ? jtb_pkg::TAP_SEL_DR : jtb_pkg::TAP_IDLE;
            end
            jtb_pkg::TAP_SEL_IR: begin
                state_nxt = tms_s ? jtb_pkg::TAP_RESET
                                  : jtb_pkg::TAP_CAPTURE_IR;
            end
            jtb_pkg::TAP_CAPTURE_IR, jtb_pkg::TAP_SHIFT_IR: begin
                state_nxt = tms_s ? jtb_pkg::TAP_EXIT1_IR
                                  : jtb_pkg::TAP_SHIFT_IR;
            end
            jtb_pkg::TAP_EXIT1_IR: begin
                state_nxt = tms_s ? jtb_pkg::TAP_UPDATE_IR
                                  : jtb_pkg::TAP_PAUSE_IR;
            end
            jtb_pkg::TAP_PAUSE_IR: begin
                state_nxt = tms_s ? jtb_pkg::TAP_EXIT2_IR
                                  : jtb_pkg::TAP_PAUSE_IR;
            end
            jtb_pkg::TAP_EXIT2_IR: begin
                state_nxt = tms_s ? jtb_pkg::TAP_UPDATE_IR
                                  : jtb_pkg::TAP_SHIFT_IR;
            end
            default: begin
                state_nxt = jtb_pkg::TAP_RESET;
            end
        endcase
    end

    // No test reset pin exists; the chip reset stands in for it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= jtb_pkg::TAP_RESET;
        end else if (!port_active) begin
            state_r <= jtb_pkg::TAP_RESET;
        end else if (tck_rise) begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    logic [jtb_pkg::IR_LEN-1:0] ir_sh_r;
    logic [jtb_pkg::IR_LEN-1:0] ir_r;

    // Unknown codes fall back to bypass so the chain never breaks
    function automatic jtb_pkg::jtb_sel_type sel_of(
        input logic [jtb_pkg::IR_LEN-1:0] code);
        case (code)
            jtb_pkg::IR_EXTEST, jtb_pkg::IR_SAMPLE,
            jtb_pkg::IR_INTEST: sel_of = jtb_pkg::SEL_BSR;
            jtb_pkg::IR_IDCODE: sel_of = jtb_pkg::SEL_IDCODE;
            jtb_pkg::IR_HIGHZ: sel_of = jtb_pkg::SEL_BYPASS;
            default: sel_of = jtb_pkg::SEL_BYPASS;
        endcase
    endfunction

    // Shifting all ones in leaves the bypass code behind
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_sh_r <= jtb_pkg::IR_CAPTURE;
        end else if (tck_rise) begin
            if (state_r == jtb_pkg::TAP_CAPTURE_IR) begin
                ir_sh_r <= jtb_pkg::IR_CAPTURE;
            end else if (state_r == jtb_pkg::TAP_SHIFT_IR) begin
                ir_sh_r <= {tdi_s, ir_sh_r[jtb_pkg::IR_LEN-1:1]};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_r <= jtb_pkg::IR_IDCODE;
        end else if (state_r == jtb_pkg::TAP_RESET) begin
            ir_r <= jtb_pkg::IR_IDCODE;
        end else if (tck_fall && state_r == jtb_pkg::TAP_UPDATE_IR) begin
            ir_r <= ir_sh_r;
        end
    end

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    jtb_pkg::jtb_sel_type sel;
    logic bypass_r;
    logic [jtb_pkg::ID_LEN-1:0] id_sh_r;
    logic [jtb_pkg::BSR_LEN-1:0] bsr_sh_r;
    logic [jtb_pkg::BSR_LEN-1:0] bsr_upd_r;
    logic cap_dr;
    logic shift_dr;

    assign sel = sel_of(ir_r);
    assign cap_dr = tck_rise && state_r == jtb_pkg::TAP_CAPTURE_DR;
    assign shift_dr = tck_rise && state_r == jtb_pkg::TAP_SHIFT_DR;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bypass_r <= 1'b0;
        end else if (cap_dr && sel == jtb_pkg::SEL_BYPASS) begin
            bypass_r <= 1'b0;
        end else if (shift_dr && sel == jtb_pkg::SEL_BYPASS) begin
            bypass_r <= tdi_s;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            id_sh_r <= jtb_pkg::IDCODE_VALUE;
        end else if (cap_dr && sel == jtb_pkg::SEL_IDCODE) begin
            id_sh_r <= jtb_pkg::IDCODE_VALUE;
        end else if (shift_dr && sel == jtb_pkg::SEL_IDCODE) begin
            id_sh_r <= {tdi_s, id_sh_r[jtb_pkg::ID_LEN-1:1]};
        end
    end

    // Capture snapshots live pins and core drive; shifting never
    // touches what the pads or the core see
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bsr_sh_r <= '0;
        end else if (cap_dr && sel == jtb_pkg::SEL_BSR) begin
            bsr_sh_r <= {core_oe_n, core_out, pad_s2_r};
        end else if (shift_dr && sel == jtb_pkg::SEL_BSR) begin
            bsr_sh_r <= {tdi_s, bsr_sh_r[jtb_pkg::BSR_LEN-1:1]};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bsr_upd_r <= '0;
        end else if (tck_fall && state_r == jtb_pkg::TAP_UPDATE_DR &&
                     sel == jtb_pkg::SEL_BSR) begin
            bsr_upd_r <= bsr_sh_r;
        end
    end

    // ------------------------------------------------------------
    // Serial output path through the two-entry buffer
    // ------------------------------------------------------------
    logic ser_out;
    logic shifting;
    logic push_pend_r;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [1:0] buf_out_data;
    logic tdo_bit_r;
    logic tdo_en_r;

    assign shifting = (state_r == jtb_pkg::TAP_SHIFT_DR) ||
                      (state_r == jtb_pkg::TAP_SHIFT_IR);

    always_comb begin
        ser_out = bypass_r;
        if (state_r == jtb_pkg::TAP_SHIFT_IR) begin
            ser_out = ir_sh_r[0];
        end else if (sel == jtb_pkg::SEL_IDCODE) begin
            ser_out = id_sh_r[0];
        end else if (sel == jtb_pkg::SEL_BSR) begin
            ser_out = bsr_sh_r[0];
        end
    end

    // One entry is queued after each rising edge; a full buffer
    // holds it pending instead of losing it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            push_pend_r <= 1'b0;
        end else if (tck_rise) begin
            push_pend_r <= 1'b1;
        end else if (buf_in_ready) begin
            push_pend_r <= 1'b0;
        end
    end

    jtb_buf2 u_tdo_buf (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(push_pend_r),
        .in_ready(buf_in_ready),
        .in_data({shifting, ser_out}),
        .out_valid(buf_out_valid),
        .out_ready(tck_fall),
        .out_data(buf_out_data)
    );

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tdo_bit_r <= 1'b1;
            tdo_en_r <= 1'b0;
        end else if (!port_active) begin
            tdo_en_r <= 1'b0;
        end else if (tck_fall && buf_out_valid) begin
            tdo_bit_r <= buf_out_data[0];
            tdo_en_r <= buf_out_data[1];
        end
    end

    // ------------------------------------------------------------
    // Pin ownership and system pads
    // ------------------------------------------------------------
    logic extest_mode;
    logic intest_mode;
    logic highz_mode;

    assign extest_mode = (ir_r == jtb_pkg::IR_EXTEST);
    assign intest_mode = (ir_r == jtb_pkg::IR_INTEST);
    assign highz_mode = (ir_r == jtb_pkg::IR_HIGHZ);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tdo_pin_out <= 1'b1;
            tdo_pin_oe_n <= 1'b1;
            user_test_pin_in <= jtb_pkg::PULLED_HIGH;
            test_pin_pullup_en <= jtb_pkg::PULLUP_ALL;
        end else begin
            test_pin_pullup_en <= jtb_pkg::PULLUP_ALL;
            if (port_active) begin
                tdo_pin_out <= tdo_bit_r;
                tdo_pin_oe_n <= ~tdo_en_r;
                user_test_pin_in <= jtb_pkg::PULLED_HIGH;
            end else begin
                tdo_pin_out <= user_tdo_out;
                tdo_pin_oe_n <= user_tdo_oe_n;
                user_test_pin_in <= tpin_s2_r;
            end
        end
    end

    // Core keeps running from its own pads except in internal test
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pad_out <= '0;
            pad_oe_n <= '1;
            core_in <= '0;
        end else begin
            if (highz_mode) begin
                pad_out <= core_out;
                pad_oe_n <= '1;
            end else if (extest_mode || intest_mode) begin
                pad_out <= bsr_upd_r[jtb_pkg::BSR_OUT_LSB +: N];
                pad_oe_n <= bsr_upd_r[jtb_pkg::BSR_OE_LSB +: N];
            end else begin
                pad_out <= core_out;
                pad_oe_n <= core_oe_n;
            end
            if (intest_mode) begin
                core_in <= bsr_upd_r[jtb_pkg::BSR_IN_LSB +: N];
            end else begin
                core_in <= pad_s2_r;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/jtb_ctl_model.sv ----
// Behavioural model of the external boundary-scan controller
`default_nettype none
module jtb_ctl_model (
    input wire logic sys_clk,
    input wire logic tdo_wire,
    output var logic tck,
    output var logic tms,
    output var logic tdi
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        // Idle high like the pin's pull-up, so reset sees no false edge
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One test clock; the caller enters on a system clock edge
    task automatic step(input logic m, input logic d, output logic q);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge sys_clk);
        tck <= 1'b1;
        repeat (4) @(posedge sys_clk);
        // Read late in the high half: output moved at the last fall
        q = tdo_wire;
    endtask
    // Five mode-select highs always reach the reset state
    task automatic go_idle();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
    // Instruction or data scan from idle back to idle
    task automatic scan(input logic ir, input int n,
        input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
endmodule
`default_nettype wire

// ---- verification/jtb_tap_port_checker.sv ----
// Port assertions for the test access port
`default_nettype none
module jtb_tap_port_checker (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic tck_pin_in,
    input wire logic port_enable_in,
    input wire logic cfg_erased,
    input wire logic cfg_test_pins_io,
    input wire logic user_tdo_out,
    input wire logic user_tdo_oe_n,
    input wire logic tdo_pin_out,
    input wire logic tdo_pin_oe_n,
    input wire logic [3:0] test_pin_pullup_en,
    input wire logic [2:0] user_test_pin_in,
    input wire logic [3:0] pad_in,
    input wire logic [3:0] pad_out,
    input wire logic [3:0] core_out,
    input wire logic [3:0] core_oe_n,
    input wire logic [3:0] pad_oe_n,
    input wire logic [3:0] core_in
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // Cycles the test clock pin has been seen high
    logic [3:0] hi_cnt_r;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_cnt_r <= 4'h0;
        end else if (!tck_pin_in) begin
            hi_cnt_r <= 4'h0;
        end else if (hi_cnt_r != 4'hf) begin
            hi_cnt_r <= hi_cnt_r + 4'h1;
        end
    end
    // Windows long enough to cover the pin synchronisers
    sequence s_user;
        (!cfg_erased && cfg_test_pins_io && !port_enable_in)[*5];
    endsequence
    sequence s_act;
        (cfg_erased || port_enable_in)[*5];
    endsequence
    property p_pullup;
        test_pin_pullup_en == 4'hf;
    endproperty
    property p_quiet;
        $rose(reset_n) |-> tdo_pin_oe_n[*8];
    endproperty
    property p_user_oe;
        s_user |-> tdo_pin_oe_n == user_tdo_oe_n;
    endproperty
    property p_user_out;
        s_user |-> tdo_pin_out == user_tdo_out;
    endproperty
    property p_act_pins;
        s_act |-> user_test_pin_in == 3'h7;
    endproperty
    property p_fall;
        cfg_erased && $changed(tdo_pin_out) |-> hi_cnt_r < 4'h3;
    endproperty
    property p_pads;
        s_user |-> pad_out == $past(core_out) && pad_oe_n == $past(core_oe_n);
    endproperty
    property p_core_in;
        (s_user and $stable(pad_in)[*5]) |-> core_in == pad_in;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up enable dropped");
    a_quiet: assert property (p_quiet)
        else $error("data-out driven just after reset");
    a_user_oe: assert property (p_user_oe)
        else $error("data-out enable not from user");
    a_user_out: assert property (p_user_out)
        else $error("data-out value not from user");
    a_act_pins: assert property (p_act_pins)
        else $error("test pins leak to user logic");
    a_fall: assert property (p_fall)
        else $error("data-out moved away from a falling edge");
    a_pads: assert property (p_pads)
        else $error("pads not following core");
    a_core_in: assert property (p_core_in)
        else $error("core input not following pads");
endmodule
bind jtb_tap_port jtb_tap_port_checker u_chk (.sys_clk, .reset_n,
    .tck_pin_in, .port_enable_in, .cfg_erased, .cfg_test_pins_io,
    .user_tdo_out, .user_tdo_oe_n, .tdo_pin_out, .tdo_pin_oe_n,
    .test_pin_pullup_en, .user_test_pin_in, .pad_in, .pad_out,
    .core_out, .core_oe_n, .pad_oe_n, .core_in);
`default_nettype wire

// ---- verification/jtb_tap_port_test.sv ----
// Self-checking bench for the test access port
`default_nettype none
module jtb_tap_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic port_enable_in = 1'b0;
    // Pins marked as user I/O, so only the erased state or the reclaim pin opens the port
    logic cfg_erased = 1'b1;
    logic cfg_test_pins_io = 1'b1;
    logic user_tdo_out = 1'b0;
    logic user_tdo_oe_n = 1'b0;
    logic [3:0] pad_in = 4'h9;
    logic [3:0] core_out = 4'h6;
    logic [3:0] core_oe_n = 4'h3;
    logic tck_pin_in, tms_pin_in, tdi_pin_in, tdo_pin_out, tdo_pin_oe_n;
    logic tdo_wire;
    logic [2:0] user_test_pin_in;
    logic [3:0] pad_out, pad_oe_n, core_in;
    logic [31:0] got;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    always #50 sys_clk = ~sys_clk;
    // Released data-out line is held high by its pull-up
    assign tdo_wire = tdo_pin_oe_n ? 1'b1 : tdo_pin_out;
    jtb_ctl_model u_ctl (.sys_clk, .tdo_wire, .tck(tck_pin_in),
        .tms(tms_pin_in), .tdi(tdi_pin_in));
    jtb_tap_port u_dut (.sys_clk, .reset_n, .tck_pin_in, .tms_pin_in,
        .tdi_pin_in, .tdo_pin_out, .tdo_pin_oe_n, .port_enable_in,
        .cfg_erased, .cfg_test_pins_io, .test_pin_pullup_en(),
        .user_test_pin_in, .user_tdo_out, .user_tdo_oe_n, .pad_in,
        .pad_out, .pad_oe_n, .core_out, .core_oe_n, .core_in);
    task automatic check(input logic [31:0] g, input logic [31:0] e,
        input string what);
        checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 10000) begin
            fails++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_read_id();
        u_ctl.scan(1'b0, 32, 32'h0, got);
        check(got, jtb_pkg::IDCODE_VALUE, "id word");
        check({31'h0, tdo_pin_oe_n}, 32'h1, "data-out released");
    endtask
    task automatic t_bypass();
        logic [4:0] codes [3] = '{5'h1f, 5'h09, jtb_pkg::IR_HIGHZ};
        foreach (codes[i]) begin
            u_ctl.scan(1'b1, 5, {27'h0, codes[i]}, got);
            check(got, 32'h1, "instruction capture");
            u_ctl.scan(1'b0, 8, 32'ha5, got);
            check(got, 32'h4a, "one stage of delay");
            if (i == 2) begin
                check({28'h0, pad_oe_n}, 32'hf, "pads float");
            end
        end
    endtask
    task automatic t_boundary();
        u_ctl.scan(1'b1, 5, {27'h0, jtb_pkg::IR_SAMPLE}, got);
        u_ctl.scan(1'b0, 12, 32'ha5c, got);
        check(got, 32'h369, "pin snapshot");
        check({28'h0, pad_out}, {28'h0, core_out}, "pads kept");
        u_ctl.scan(1'b1, 5, {27'h0, jtb_pkg::IR_EXTEST}, got);
        check({24'h0, pad_oe_n, pad_out}, 32'ha5, "pads from latch");
        u_ctl.scan(1'b1, 5, {27'h0, jtb_pkg::IR_INTEST}, got);
        check({28'h0, core_in}, 32'hc, "core from latch");
    endtask
    task automatic t_reclaim();
        cfg_erased <= 1'b0;
        cfg_test_pins_io <= 1'b1;
        repeat (8) @(posedge sys_clk);
        u_ctl.scan(1'b0, 32, 32'h0, got);
        check(got, 32'h0, "pins stay user I/O");
        check({29'h0, user_test_pin_in}, 32'h5, "pins to user");
        port_enable_in <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check({29'h0, user_test_pin_in}, 32'h7, "pins reclaimed");
        u_ctl.go_idle();
        t_read_id();
        port_enable_in <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check({31'h0, tdo_pin_oe_n}, 32'h0, "user drive back");
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        u_ctl.step(1'b0, 1'b1, got[0]);
        t_read_id();
        t_bypass();
        t_boundary();
        t_reclaim();
        end_of_test();
    end
endmodule
`default_nettype wire
